// file: logic/rdl_consts.svh
`ifndef RDL_CONSTS_SVH
`define RDL_CONSTS_SVH
// Register indices (word address on the bus)
`define RDL_REG_CMD 4'h0
`define RDL_REG_SA_SEL 4'h1
`define RDL_REG_REPEAT 4'h2
`define RDL_REG_RX_CTRL 4'h3
`define RDL_REG_INT_EN 4'h4
`define RDL_REG_TRANSP 4'h5
`define RDL_REG_MATCH 4'h6
`define RDL_REG_STATUS 4'h7
`define RDL_REG_CODE 4'h8
`define RDL_REG_FIFO 4'h9
// Field positions
`define RDL_CMD_RESET 0
`define RDL_CMD_RESTART 1
`define RDL_RXC_ENABLE 2
`define RDL_RXC_PRM 6
`define RDL_INT_BOM 7
`define RDL_TR_MATCH 5
`define RDL_TR_MODE 6
`define RDL_ST_BOM 7
`define RDL_ST_NEMPTY 0
`define RDL_SF_BADCRC 7
`define RDL_SF_ABORT 6
`define RDL_SF_OVR 5
`define RDL_SF_BADCNT 4
// Counts and values
`define RDL_SWRST_CYCLES 3'h4
`define RDL_REPEAT_MIN 4'h1
`define RDL_REPEAT_MAX 4'ha
`define RDL_PRM_BYTES 5'h0d
`define RDL_FCS_BYTES 5'h02
`define RDL_SA_LAST 3'h4
`define RDL_BOM_LEAD 8'hff
`define RDL_CRC_INIT 16'hffff
`define RDL_CRC_POLY 16'h8408
`define RDL_CRC_GOOD 16'hf0b8
`define RDL_STUFF_ONES 3'h5
`define RDL_FLAG_ONES 3'h6
`define RDL_ABORT_ONES 3'h7
`define RDL_LAST_BIT 3'h7
`endif

// file: logic/rdl_pkg.sv
package rdl_pkg;
  // HDLC deframer states, Gray coded
  typedef enum logic [1:0] {
    HUNT = 2'b00,
    IN_FRAME = 2'b01
  } hdlc_state_t;
endpackage : rdl_pkg

// file: logic/receive_data_link_controller.sv
// Our own choices: register access over Avalon-MM and the address map.
`include "rdl_consts.svh"

// Function
// - Reset command: four-cycle reset, parameters default
// - Restart bit holds reset, keeps parameters
// - E1 link bit chosen by Sa select
// - Received bytes buffered in 64-byte FIFO
// - Serial data and clock out in parallel
// - Message is eight ones, zero, six codes, zero
// - Repeat threshold 1 to 10, bits 4-7
// - Code register: bits 7-6 zero, X5..X0
// - Detected flag bit 7, cleared on read
// - Interrupt only when enable bit 7 set
// - Enabled receiver defaults to HDLC mode
// - HDLC: flags, CRC, data then status byte
// - Report mode stores 13 bytes plus status
// - Transparent mode packs bits straight in
// - Pattern match: store from match character on
// - Check bytes dropped except in report mode
// - Status byte: CRC, abort, overrun, count bits
// - n-byte frame uses n+1 FIFO entries
module receive_data_link_controller #(
  parameter int FIFO_DEPTH = 64,
  parameter int PTR_W = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  // Bits from the receive framer
  input wire logic link_bit_valid,
  input wire logic t1_link_bit,
  input wire logic [4:0] sa_bits,
  input wire logic e1_mode,
  // Serial link, interrupt, framer reset
  output logic serial_link_data_out,
  output logic serial_link_clock_out,
  output logic bom_irq,
  output logic framer_reset
);

  // Whole state of the block
  typedef struct packed {
    logic [2:0] swrst_cnt;     // Software reset cycles left
    logic restart;             // Restart command level
    logic [2:0] sa_sel;        // Sa bit chosen in E1
    logic [3:0] repeat_cfg;    // Repeat threshold field
    logic rx_en;               // Receiver enable
    logic prm_en;              // Performance report mode
    logic irq_en;              // Message interrupt enable
    logic tm;                  // Transparent mode
    logic pm;                  // Pattern match
    logic [7:0] match_char;    // Match character
    logic bom_flag;            // Message detected, sticky
    logic [5:0] bom_code;      // Reported code
    logic [5:0] bom_last;      // Last code seen
    logic [3:0] bom_cnt;       // Consecutive repeats
    logic [15:0] bom_sr;       // Last sixteen link bits
    rdl_pkg::hdlc_state_t st;  // Deframer state
    logic [2:0] ones;          // Run of ones
    logic [2:0] bitc;          // Bit in byte
    logic [7:0] shreg;         // Byte assembly
    logic [4:0] byte_cnt;      // Bytes in frame, saturating
    logic [15:0] crc;          // Running check
    logic [7:0] pend0;         // Newest held byte
    logic [7:0] pend1;         // Oldest held byte
    logic [1:0] npend;         // Held byte count
    logic ovr;                 // Overrun within frame
    logic matched;             // Match character seen
    logic [7:0] tshreg;        // Transparent window
    logic [2:0] tbitc;         // Transparent bit count
    logic [FIFO_DEPTH-1:0][7:0] fifo;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [PTR_W:0] fcnt;
    logic sdo;
    logic sck;
    logic waitreq;
    logic [7:0] rdata;
    logic irq;
    logic fr_rst;
  } state_t;

  state_t cur_ff;
  state_t nxt_st;
  state_t rst_val;

  // Byte-wide CRC step, LSB first as on the wire
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `RDL_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : crc_byte

  // Reset value of every field
  always_comb begin
    rst_val = '0;
    rst_val.crc = `RDL_CRC_INIT;
    rst_val.waitreq = 1'b1;
  end

  logic link_bit;
  logic link_rst;
  logic [3:0] thr;
  logic [5:0] code;
  logic push;
  logic [7:0] push_data;
  logic pop;
  logic [7:0] byte_done;
  logic bad_cnt;
  logic bom_set;  // Message accepted this cycle

  // Next state
  always_comb begin
    nxt_st = cur_ff;
    push = 1'b0;
    push_data = 8'h00;
    pop = 1'b0;
    byte_done = 8'h00;
    bad_cnt = 1'b0;
    bom_set = 1'b0;
    // Link bit: T1 data link or the chosen Sa bit
    if (e1_mode) begin
      link_bit = (cur_ff.sa_sel > `RDL_SA_LAST) ? sa_bits[0] :
                 sa_bits[cur_ff.sa_sel];
    end else begin
      link_bit = t1_link_bit;
    end
    // Threshold clamped into its legal range
    if (cur_ff.repeat_cfg < `RDL_REPEAT_MIN) begin
      thr = `RDL_REPEAT_MIN;
    end else if (cur_ff.repeat_cfg > `RDL_REPEAT_MAX) begin
      thr = `RDL_REPEAT_MAX;
    end else begin
      thr = cur_ff.repeat_cfg;
    end
    // Code bits of the last fifteen; X0 came first, X5 last
    code = {cur_ff.bom_sr[0], cur_ff.bom_sr[1], cur_ff.bom_sr[2],
            cur_ff.bom_sr[3], cur_ff.bom_sr[4], cur_ff.bom_sr[5]};
    link_rst = (cur_ff.swrst_cnt != 3'h0) || cur_ff.restart;

    // Software reset countdown
    if (cur_ff.swrst_cnt != 3'h0) begin
      nxt_st.swrst_cnt = cur_ff.swrst_cnt - 3'h1;
    end

    // Serial copy of the link, one clock pulse per bit
    nxt_st.sck = link_bit_valid && !link_rst;
    if (link_bit_valid && !link_rst) begin
      nxt_st.sdo = link_bit;
    end

    if (link_rst) begin
      // Data link logic held in reset, parameters untouched
      nxt_st.bom_flag = 1'b0;
      nxt_st.bom_code = '0;
      nxt_st.bom_last = '0;
      nxt_st.bom_cnt = '0;
      nxt_st.bom_sr = '0;
      nxt_st.st = rdl_pkg::HUNT;
      nxt_st.ones = '0;
      nxt_st.bitc = '0;
      nxt_st.byte_cnt = '0;
      nxt_st.crc = `RDL_CRC_INIT;
      nxt_st.npend = '0;
      nxt_st.ovr = 1'b0;
      nxt_st.matched = 1'b0;
      nxt_st.tbitc = '0;
      nxt_st.wptr = '0;
      nxt_st.rptr = '0;
      nxt_st.fcnt = '0;
    end else if (link_bit_valid) begin
      // Message monitor; newest bit enters at bit 0
      nxt_st.bom_sr = {cur_ff.bom_sr[14:0], link_bit};
      if (cur_ff.bom_sr[14:7] == `RDL_BOM_LEAD && !cur_ff.bom_sr[6]
          && !link_bit) begin
        // Frame of one message complete
        if (code == cur_ff.bom_last && cur_ff.bom_cnt != 4'h0) begin
          if (cur_ff.bom_cnt != `RDL_REPEAT_MAX) begin
            nxt_st.bom_cnt = cur_ff.bom_cnt + 4'h1;
          end
        end else begin
          nxt_st.bom_cnt = 4'h1;
        end
        nxt_st.bom_last = code;
        // Report once, when the run reaches the threshold
        if (nxt_st.bom_cnt == thr &&
            !(code == cur_ff.bom_last && cur_ff.bom_cnt >= thr)) begin
          nxt_st.bom_code = code;
          nxt_st.bom_flag = 1'b1;
          bom_set = 1'b1;
        end
      end

      if (cur_ff.rx_en && cur_ff.tm) begin
        // Transparent packing, optionally gated by a match
        nxt_st.tshreg = {link_bit, cur_ff.tshreg[7:1]};
        if (!cur_ff.pm || cur_ff.matched) begin
          nxt_st.tbitc = cur_ff.tbitc + 3'h1;
          if (cur_ff.tbitc == `RDL_LAST_BIT) begin
            push = 1'b1;
            push_data = nxt_st.tshreg;
          end
        end else if (nxt_st.tshreg == cur_ff.match_char) begin
          // Match byte stored, alignment taken from it
          nxt_st.matched = 1'b1;
          nxt_st.tbitc = 3'h0;
          push = 1'b1;
          push_data = nxt_st.tshreg;
        end
      end else if (cur_ff.rx_en) begin
        // HDLC deframing is the default receive mode
        if (!link_bit) begin
          nxt_st.ones = 3'h0;
          if (cur_ff.ones == `RDL_FLAG_ONES) begin
            // Flag: close any open frame, then start afresh
            if (cur_ff.st == rdl_pkg::IN_FRAME &&
                cur_ff.byte_cnt != 5'h0) begin
              if (cur_ff.prm_en) begin
                bad_cnt = cur_ff.byte_cnt != `RDL_PRM_BYTES;
              end else begin
                bad_cnt = cur_ff.byte_cnt <= `RDL_FCS_BYTES;
              end
              push = 1'b1;
              push_data = 8'h00;
              push_data[`RDL_SF_BADCRC] = cur_ff.crc != `RDL_CRC_GOOD;
              push_data[`RDL_SF_OVR] = cur_ff.ovr;
              push_data[`RDL_SF_BADCNT] = bad_cnt ||
                                          cur_ff.bitc != `RDL_LAST_BIT;
            end
            nxt_st.st = rdl_pkg::IN_FRAME;
            nxt_st.bitc = '0;
            nxt_st.byte_cnt = '0;
            nxt_st.crc = `RDL_CRC_INIT;
            nxt_st.npend = '0;
            nxt_st.ovr = 1'b0;
          end else if (cur_ff.ones != `RDL_STUFF_ONES &&
                       cur_ff.st == rdl_pkg::IN_FRAME) begin
            // Plain zero data bit; a stuffed zero is dropped
            nxt_st.shreg = {1'b0, cur_ff.shreg[7:1]};
            nxt_st.bitc = cur_ff.bitc + 3'h1;
          end
        end else begin
          if (cur_ff.ones != `RDL_ABORT_ONES) begin
            nxt_st.ones = cur_ff.ones + 3'h1;
          end
          if (cur_ff.ones == `RDL_FLAG_ONES &&
              cur_ff.st == rdl_pkg::IN_FRAME) begin
            // Seventh one: abort, report only a started frame
            if (cur_ff.byte_cnt != 5'h0) begin
              push = 1'b1;
              push_data = 8'h00;
              push_data[`RDL_SF_ABORT] = 1'b1;
              push_data[`RDL_SF_OVR] = cur_ff.ovr;
            end
            nxt_st.st = rdl_pkg::HUNT;
          end else if (cur_ff.st == rdl_pkg::IN_FRAME) begin
            nxt_st.shreg = {1'b1, cur_ff.shreg[7:1]};
            nxt_st.bitc = cur_ff.bitc + 3'h1;
          end
        end
        // Completed byte: check, then store or hold back
        if (nxt_st.st == rdl_pkg::IN_FRAME && !push &&
            cur_ff.bitc == `RDL_LAST_BIT && nxt_st.bitc == 3'h0 &&
            cur_ff.ones != `RDL_FLAG_ONES) begin
          byte_done = nxt_st.shreg;
          nxt_st.crc = crc_byte(cur_ff.crc, byte_done);
          if (cur_ff.byte_cnt != 5'h1f) begin
            nxt_st.byte_cnt = cur_ff.byte_cnt + 5'h1;
          end
          if (cur_ff.prm_en) begin
            // Report frames keep their check bytes
            push = 1'b1;
            push_data = byte_done;
          end else begin
            // Two bytes held back so the check bytes drop
            if (cur_ff.npend == 2'h2) begin
              push = 1'b1;
              push_data = cur_ff.pend1;
            end else begin
              nxt_st.npend = cur_ff.npend + 2'h1;
            end
            nxt_st.pend1 = (cur_ff.npend == 2'h0) ? byte_done :
                           cur_ff.pend0;
            nxt_st.pend0 = byte_done;
          end
        end
      end
    end

    // Bus handshake: first edge answers, second edge commits
    nxt_st.waitreq = 1'b1;
    if ((avs_read || avs_write) && cur_ff.waitreq) begin
      nxt_st.waitreq = 1'b0;
      nxt_st.rdata = 8'h00;
      unique case (avs_address)
        `RDL_REG_CMD: nxt_st.rdata[`RDL_CMD_RESTART] = cur_ff.restart;
        `RDL_REG_SA_SEL: nxt_st.rdata[2:0] = cur_ff.sa_sel;
        `RDL_REG_REPEAT: nxt_st.rdata[7:4] = cur_ff.repeat_cfg;
        `RDL_REG_RX_CTRL: begin
          nxt_st.rdata[`RDL_RXC_ENABLE] = cur_ff.rx_en;
          nxt_st.rdata[`RDL_RXC_PRM] = cur_ff.prm_en;
        end
        `RDL_REG_INT_EN: nxt_st.rdata[`RDL_INT_BOM] = cur_ff.irq_en;
        `RDL_REG_TRANSP: begin
          nxt_st.rdata[`RDL_TR_MODE] = cur_ff.tm;
          nxt_st.rdata[`RDL_TR_MATCH] = cur_ff.pm;
        end
        `RDL_REG_MATCH: nxt_st.rdata = cur_ff.match_char;
        `RDL_REG_STATUS: begin
          nxt_st.rdata[`RDL_ST_BOM] = cur_ff.bom_flag;
          nxt_st.rdata[`RDL_ST_NEMPTY] = cur_ff.fcnt != '0;
        end
        `RDL_REG_CODE: nxt_st.rdata = {2'b00, cur_ff.bom_code};
        `RDL_REG_FIFO: nxt_st.rdata = cur_ff.fifo[cur_ff.rptr];
        default: nxt_st.rdata = 8'h00;  // Unmapped reads as zero
      endcase
    end else if (avs_read && !cur_ff.waitreq) begin
      // Read side effects at the completing edge
      if (avs_address == `RDL_REG_STATUS && cur_ff.rdata[`RDL_ST_BOM]) begin
        nxt_st.bom_flag = bom_set;  // a new detection wins
      end
      pop = avs_address == `RDL_REG_FIFO && cur_ff.fcnt != '0 && !link_rst;
    end else if (avs_write && !cur_ff.waitreq) begin
      unique case (avs_address)
        `RDL_REG_CMD: begin
          if (avs_writedata[`RDL_CMD_RESET]) begin
            // Parameters to defaults, four cycles of reset
            nxt_st.sa_sel = rst_val.sa_sel;
            nxt_st.repeat_cfg = rst_val.repeat_cfg;
            nxt_st.rx_en = rst_val.rx_en;
            nxt_st.prm_en = rst_val.prm_en;
            nxt_st.irq_en = rst_val.irq_en;
            nxt_st.tm = rst_val.tm;
            nxt_st.pm = rst_val.pm;
            nxt_st.match_char = rst_val.match_char;
            nxt_st.swrst_cnt = `RDL_SWRST_CYCLES;
          end
          nxt_st.restart = avs_writedata[`RDL_CMD_RESTART];
        end
        `RDL_REG_SA_SEL: nxt_st.sa_sel = avs_writedata[2:0];
        `RDL_REG_REPEAT: nxt_st.repeat_cfg = avs_writedata[7:4];
        `RDL_REG_RX_CTRL: begin
          nxt_st.rx_en = avs_writedata[`RDL_RXC_ENABLE];
          nxt_st.prm_en = avs_writedata[`RDL_RXC_PRM];
        end
        `RDL_REG_INT_EN: nxt_st.irq_en = avs_writedata[`RDL_INT_BOM];
        `RDL_REG_TRANSP: begin
          nxt_st.tm = avs_writedata[`RDL_TR_MODE];
          nxt_st.pm = avs_writedata[`RDL_TR_MATCH];
        end
        `RDL_REG_MATCH: nxt_st.match_char = avs_writedata;
        default: nxt_st.restart = cur_ff.restart;  // Ignored write
      endcase
    end

    // FIFO: push and pop may share a cycle
    if (push) begin
      if (cur_ff.fcnt < (PTR_W + 1)'(FIFO_DEPTH) || pop) begin
        nxt_st.fifo[cur_ff.wptr] = push_data;
        nxt_st.wptr = cur_ff.wptr + 1'b1;
      end else begin
        nxt_st.ovr = 1'b1;  // Full: byte lost, frame flagged
      end
    end
    if (pop) begin
      nxt_st.rptr = cur_ff.rptr + 1'b1;
    end
    if (push && !pop && cur_ff.fcnt < (PTR_W + 1)'(FIFO_DEPTH)) begin
      nxt_st.fcnt = cur_ff.fcnt + 1'b1;
    end else if (pop && !push) begin
      nxt_st.fcnt = cur_ff.fcnt - 1'b1;
    end

    nxt_st.irq = nxt_st.bom_flag && nxt_st.irq_en;
    nxt_st.fr_rst = (nxt_st.swrst_cnt != 3'h0) || nxt_st.restart;
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_ff <= rst_val;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = cur_ff.rdata;
  assign avs_waitrequest = cur_ff.waitreq;
  assign serial_link_data_out = cur_ff.sdo;
  assign serial_link_clock_out = cur_ff.sck;
  assign bom_irq = cur_ff.irq;
  assign framer_reset = cur_ff.fr_rst;

endmodule : receive_data_link_controller

// file: verif/fdl_bit_source.sv
module fdl_bit_source (
  // Clock
  input wire logic core_clk,
  // Chosen Sa position
  input wire logic [2:0] sa_sel,
  // Link bits into the block
  output logic link_bit_valid,
  output logic t1_link_bit,
  output logic [4:0] sa_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap = 0; // Idle cycles per bit, nonzero for a slow framer
  logic [15:0] fcs_q = 16'h0000; // Last check word sent
  initial begin
    link_bit_valid = 1'b0;
    t1_link_bit = 1'b0;
    sa_bits = 5'h00;
  end
  // Idle: lines keep changing so stale data cannot pass
  task automatic rest();
    @(posedge core_clk);
    link_bit_valid <= 1'b0;
    t1_link_bit <= ~t1_link_bit;
    sa_bits <= ~sa_bits;
  endtask : rest
  // One bit; Sa pins not chosen carry the inverse
  task automatic put(input logic b);
    logic [4:0] oh;
    oh = 5'h01 << sa_sel;
    @(posedge core_clk);
    link_bit_valid <= 1'b1;
    t1_link_bit <= b;
    sa_bits <= b ? oh : ~oh;
    repeat (gap) rest();
  endtask : put
  // First bit is v[0]
  task automatic send(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      put(v[i]);
    end
    rest();
  endtask : send
  // Reflected CRC-16 step, one byte
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    return c;
  endfunction : crc_step
  // Flag, stuffed bytes and check word, flag
  task automatic frame(input logic [7:0] d [16], input int n,
                       input logic bad);
    logic [15:0] c;
    logic [7:0] b;
    int ones;
    c = 16'hffff;
    ones = 0;
    for (int i = 0; i < n; i++) begin
      c = crc_step(c, d[i]);
    end
    fcs_q = ~c ^ {15'h0000, bad};
    send(32'h7e, 8);
    for (int i = 0; i < n + 2; i++) begin
      b = (i < n) ? d[i] : ((i == n) ? fcs_q[7:0] : fcs_q[15:8]);
      for (int k = 0; k < 8; k++) begin
        put(b[k]);
        ones = b[k] ? ones + 1 : 0;
        if (ones == 5) begin
          put(1'b0);
          ones = 0;
        end
      end
    end
    send(32'h7e, 8);
  endtask : frame
endmodule : fdl_bit_source

// file: verif/rdl_props.sv
`include "rdl_consts.svh"

module rdl_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  input wire logic [7:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Framer side and outputs
  input wire logic link_bit_valid,
  input wire logic t1_link_bit,
  input wire logic [4:0] sa_bits,
  input wire logic e1_mode,
  input wire logic serial_link_data_out,
  input wire logic serial_link_clock_out,
  input wire logic bom_irq,
  input wire logic framer_reset
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Bus completions at the committing edge
  logic wr_done;
  logic rd_done;
  assign wr_done = avs_write && !avs_waitrequest;
  assign rd_done = avs_read && !avs_waitrequest;
  // Shadow of restart and interrupt enable
  typedef struct packed {
    logic restart;
    logic int_en;
  } mon_t;
  mon_t mon_ff;
  mon_t nxt_mon;
  // Reset command returns the enable to default
  always_comb begin
    nxt_mon = mon_ff;
    if (wr_done && avs_address == `RDL_REG_CMD) begin
      nxt_mon.restart = avs_writedata[1] & ~avs_writedata[0];
      if (avs_writedata[0]) begin
        nxt_mon.int_en = 1'b0;
      end
    end else if (wr_done && avs_address == `RDL_REG_INT_EN) begin
      nxt_mon.int_en = avs_writedata[`RDL_INT_BOM];
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mon_ff <= '0;
    end else begin
      mon_ff <= nxt_mon;
    end
  end
  // Reset command and its four-cycle hold
  sequence s_reset_cmd;
    wr_done && avs_address == `RDL_REG_CMD && avs_writedata[1:0] == 2'b01;
  endsequence
  sequence s_hold_four;
    framer_reset [*4] ##1 !framer_reset;
  endsequence
  chk_reset_four: assert property (s_reset_cmd |=> s_hold_four)
    else $error("framer reset not held four cycles");
  chk_restart_hold: assert property (
    mon_ff.restart && $past(mon_ff.restart) |-> framer_reset)
    else $error("framer reset low while restart set");
  chk_serial_copy: assert property (
    link_bit_valid && !e1_mode && !framer_reset |=>
    serial_link_clock_out && serial_link_data_out == $past(t1_link_bit))
    else $error("serial copy of link bit wrong");
  chk_clock_cause: assert property (
    serial_link_clock_out |-> $past(link_bit_valid))
    else $error("serial clock without link bit");
  chk_code_top_zero: assert property (
    rd_done && avs_address == `RDL_REG_CODE |-> avs_readdata[7:6] == 2'b00)
    else $error("code register top bits not zero");
  chk_irq_enable: assert property (
    bom_irq |-> mon_ff.int_en)
    else $error("interrupt while disabled");
  chk_status_irq: assert property (
    rd_done && avs_address == `RDL_REG_STATUS && bom_irq |->
    avs_readdata[`RDL_ST_BOM])
    else $error("interrupt without message flag");
  chk_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_wait_idle: assert property (
    !avs_read && !avs_write |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  chk_unmapped_zero: assert property (
    rd_done && avs_address > `RDL_REG_FIFO |-> avs_readdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : rdl_props

bind receive_data_link_controller rdl_props i_props (
  .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .link_bit_valid(link_bit_valid),
  .t1_link_bit(t1_link_bit), .sa_bits(sa_bits), .e1_mode(e1_mode),
  .serial_link_data_out(serial_link_data_out),
  .serial_link_clock_out(serial_link_clock_out),
  .bom_irq(bom_irq), .framer_reset(framer_reset));

// file: verif/receive_data_link_controller_bench.sv
`include "rdl_consts.svh"

module receive_data_link_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 30000; // Tests need about 2000 cycles
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  logic [7:0] avs_readdata;
  logic avs_waitrequest;
  logic link_bit_valid;
  logic t1_link_bit;
  logic [4:0] sa_bits;
  logic e1_mode = 1'b0;
  logic [2:0] sa_sel = 3'h0;
  logic serial_link_data_out;
  logic serial_link_clock_out;
  logic bom_irq;
  logic framer_reset;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] d [16]; // Frame payload, shared with the reads
  always #4 core_clk = ~core_clk;
  receive_data_link_controller i_dut (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_bit_valid(link_bit_valid),
    .t1_link_bit(t1_link_bit), .sa_bits(sa_bits), .e1_mode(e1_mode),
    .serial_link_data_out(serial_link_data_out),
    .serial_link_clock_out(serial_link_clock_out),
    .bom_irq(bom_irq), .framer_reset(framer_reset));
  fdl_bit_source i_src (
    .core_clk(core_clk), .sa_sel(sa_sel), .link_bit_valid(link_bit_valid),
    .t1_link_bit(t1_link_bit), .sa_bits(sa_bits));
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      final_report();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // Avalon cycle: hold until waitrequest sampled low
  task automatic bus(input logic rd, input logic [3:0] a,
                     input logic [7:0] wd, output logic [7:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= rd;
    avs_write <= ~rd;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] wd);
    logic [7:0] q;
    bus(1'b0, a, wd, q);
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b1, a, 8'h00, q);
    check(q, exp);
  endtask : rdc
  // Message: eight ones, zero, code low bit first, zero
  task automatic bom_n(input logic [5:0] code, input int n);
    repeat (n) i_src.send({16'h0, 1'b0, code, 1'b0, 8'hff}, 16);
  endtask : bom_n
  // Restart pulse clears the datapath only
  task automatic restart();
    wr(`RDL_REG_CMD, 8'h02);
    wr(`RDL_REG_CMD, 8'h00);
  endtask : restart
  // Stored bytes of d, then the frame status byte
  task automatic read_frame(input int n, input logic [7:0] sf);
    for (int i = 0; i < n; i++) begin
      rdc(`RDL_REG_FIFO, d[i]);
    end
    rdc(`RDL_REG_FIFO, sf);
    rdc(`RDL_REG_STATUS, 8'h00);
  endtask : read_frame
  initial begin
    for (int i = 0; i < 16; i++) begin
      d[i] = 8'hf8 + 8'(i);
    end
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    // Defaults and an unmapped place
    rdc(`RDL_REG_CODE, 8'h00);
    rdc(`RDL_REG_STATUS, 8'h00);
    rdc(4'hf, 8'h00);
    // Three identical codes needed; a different code restarts
    wr(`RDL_REG_REPEAT, 8'h30);
    bom_n(6'h2a, 2);
    bom_n(6'h15, 1);
    bom_n(6'h2a, 2);
    rdc(`RDL_REG_STATUS, 8'h00);
    bom_n(6'h2a, 1);
    check({7'h00, bom_irq}, 8'h00);
    rdc(`RDL_REG_CODE, 8'h2a);
    wr(`RDL_REG_INT_EN, 8'h80);
    repeat (2) @(posedge core_clk);
    check({7'h00, bom_irq}, 8'h01);
    rdc(`RDL_REG_STATUS, 8'h80);
    repeat (2) @(posedge core_clk);
    check({7'h00, bom_irq}, 8'h00);
    rdc(`RDL_REG_STATUS, 8'h00);
    // Top of range, slow framer
    i_src.gap = 2;
    wr(`RDL_REG_REPEAT, 8'ha0);
    bom_n(6'h33, 9);
    rdc(`RDL_REG_STATUS, 8'h00);
    bom_n(6'h33, 1);
    rdc(`RDL_REG_STATUS, 8'h80);
    rdc(`RDL_REG_CODE, 8'h33);
    i_src.gap = 0;
    // E1: each Sa position in turn
    wr(`RDL_REG_REPEAT, 8'h10);
    e1_mode <= 1'b1;
    for (int s = 0; s < 5; s++) begin
      sa_sel <= 3'(s);
      wr(`RDL_REG_SA_SEL, 8'(s));
      bom_n(6'h08 + 6'(s), 1);
      rdc(`RDL_REG_CODE, 8'h08 + 8'(s));
    end
    e1_mode <= 1'b0;
    rdc(`RDL_REG_STATUS, 8'h80);
    // Software reset and restart
    wr(`RDL_REG_CMD, 8'h01);
    rdc(`RDL_REG_REPEAT, 8'h00);
    rdc(`RDL_REG_INT_EN, 8'h00);
    rdc(`RDL_REG_SA_SEL, 8'h00);
    wr(`RDL_REG_REPEAT, 8'h50);
    wr(`RDL_REG_CMD, 8'h02);
    rdc(`RDL_REG_REPEAT, 8'h50);
    check({7'h00, framer_reset}, 8'h01);
    wr(`RDL_REG_CMD, 8'h00);
    // Transparent: fill all 64 places, then drain
    wr(`RDL_REG_RX_CTRL, 8'h04);
    wr(`RDL_REG_TRANSP, 8'h40);
    for (int i = 0; i < 64; i++) begin
      i_src.send({26'h0, 6'(i)} | 32'h40, 8);
    end
    rdc(`RDL_REG_STATUS, 8'h01);
    for (int i = 0; i < 64; i++) begin
      rdc(`RDL_REG_FIFO, 8'h40 | 8'(i));
    end
    rdc(`RDL_REG_STATUS, 8'h00);
    // Nothing stored before the match character
    restart();
    wr(`RDL_REG_MATCH, 8'hc3);
    wr(`RDL_REG_TRANSP, 8'h60);
    i_src.send(32'h55c311, 24);
    rdc(`RDL_REG_FIFO, 8'hc3);
    rdc(`RDL_REG_FIFO, 8'h55);
    rdc(`RDL_REG_STATUS, 8'h00);
    // HDLC default: good frame, then bad check word
    restart();
    wr(`RDL_REG_TRANSP, 8'h00);
    i_src.frame(d, 5, 1'b0);
    read_frame(5, 8'h00);
    i_src.frame(d, 5, 1'b1);
    read_frame(5, 8'h80);
    // Report mode keeps the check word: 13 bytes
    wr(`RDL_REG_RX_CTRL, 8'h44);
    i_src.frame(d, 11, 1'b0);
    d[11] = i_src.fcs_q[7:0];
    d[12] = i_src.fcs_q[15:8];
    read_frame(13, 8'h00);
    final_report();
  end
endmodule : receive_data_link_controller_bench
